/* verilog/lxs_serial_port.sv */
`timescale 1ns/10ps
module lxs_serial_port #(
	parameter int unsigned TICK_CYC    = lxs_pkg::INT_TICK_CYC, // pwm step
	parameter bit          CLKIN_DFLT  = 1'b0  // variant: pin as clock in
) (
	input  wire logic                           clk,          // 200 MHz
	input  wire logic                           arst_n,       // async reset
	input  wire logic                           sclk,         // serial clock
	input  wire logic                           cs_n,         // chip select
	input  wire logic                           din,          // serial in
	input  wire logic                           dual_in,      // pin level
	output logic                                dual_out,     // serial out
	output logic                                dual_oe_n,    // low: driven
	input  wire logic [lxs_pkg::NUM_PORTS-1:0]  io_ports_in,  // port levels
	output logic      [lxs_pkg::NUM_PORTS-1:0]  io_ports_out, // always low
	output logic      [lxs_pkg::NUM_PORTS-1:0]  io_ports_oe_n,// low: sinking
	output logic      [lxs_pkg::NUM_PORTS-1:0]  current_full, // full current
	output logic      [2:0]                     global_current,// scale
	output logic                                shutdown      // in shutdown
);
	import lxs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; first stage feeds only the second

	logic                 sclk_s1, sclk_s2, sclk_d;
	logic                 cs_s1, cs_s2, cs_d;
	logic                 din_s1, din_s2;
	logic                 pck_s1, pck_s2, pck_d;
	logic [NUM_PORTS-1:0] io_s1, io_s2;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_d  <= 1'b0;
			cs_s1   <= 1'b1;
			cs_s2   <= 1'b1;
			cs_d    <= 1'b1;
			din_s1  <= 1'b0;
			din_s2  <= 1'b0;
			pck_s1  <= 1'b0;
			pck_s2  <= 1'b0;
			pck_d   <= 1'b0;
			io_s1   <= '0;
			io_s2   <= '0;
		end
		else
		begin
			sclk_s1 <= sclk;
			sclk_s2 <= sclk_s1;
			sclk_d  <= sclk_s2;
			cs_s1   <= cs_n;
			cs_s2   <= cs_s1;
			cs_d    <= cs_s2;
			din_s1  <= din;
			din_s2  <= din_s1;
			pck_s1  <= dual_in;
			pck_s2  <= pck_s1;
			pck_d   <= pck_s2;
			io_s1   <= io_ports_in;
			io_s2   <= io_s1;
		end
	end

	logic sck_rise, sck_fall, cs_rise, pck_rise;
	assign sck_rise = sclk_s2 & ~sclk_d & ~cs_s2;  // RL3
	assign sck_fall = ~sclk_s2 & sclk_d & ~cs_s2;  // RL3
	assign cs_rise  = cs_s2 & ~cs_d;
	assign pck_rise = pck_s2 & ~pck_d;

	////////////////////////////////////////////////////////////////////////
	// state

	logic [SR_BITS-1:0] sr, next_sr;
	logic               dout_q, next_dout_q;
	logic [7:0]         port_code [NUM_PORTS];
	logic [7:0]         next_port_code [NUM_PORTS];
	logic [9:0]         full_q, next_full_q;
	logic [2:0]         glob_q, next_glob_q;
	logic               run, next_run;
	logic               clk_sel, next_clk_sel;
	logic               strap_done, next_strap_done;
	logic [7:0]         pwm_cnt, next_pwm_cnt;
	logic [15:0]        tick_cnt, next_tick_cnt;
	logic [NUM_PORTS-1:0] oe_n_q, next_oe_n_q;

	lxs_cmd_t cmd;
	assign cmd = lxs_cmd_t'(sr);

	function automatic logic [7:0] rd_reg(input logic [6:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a < 7'(NUM_PORTS))
			v = port_code[a[3:0]];
		else if (a == ADDR_IN_LO)
			v = io_s2[7:0];
		else if (a == ADDR_IN_HI)
			v = {6'h00, io_s2[9:8]};
		else if (a == ADDR_CFG)
			v = {6'h00, clk_sel, run};
		else if (a == ADDR_FULL_LO)
			v = full_q[7:0];
		else if (a == ADDR_FULL_HI)
			v = {6'h00, full_q[9:8]};
		else if (a == ADDR_GLOB)
			v = {5'h00, glob_q};
		return v;
	endfunction : rd_reg

	// 1 = pin released; code 00 sinks always, static and PWM codes only while running
	function automatic logic port_oe_n(input logic [7:0] c,
		input logic r, input logic [7:0] n);
		if (c == CODE_LOW)
			return 1'b0;
		if (c == CODE_HIGH || c == CODE_OFF)
			return 1'b1;
		if (c == CODE_STATIC)
			return ~r;
		return ~(r && (n < c));
	endfunction : port_oe_n

	////////////////////////////////////////////////////////////////////////
	// next values

	always_comb
	begin
		next_sr         = sr;
		next_dout_q     = dout_q;
		next_port_code  = port_code;
		next_full_q     = full_q;
		next_glob_q     = glob_q;
		next_run        = run;
		next_clk_sel    = clk_sel;
		next_strap_done = 1'b1;
		next_pwm_cnt    = pwm_cnt;
		next_tick_cnt   = tick_cnt;
		// variant default caught once after reset release
		if (!strap_done)
			next_clk_sel = CLKIN_DFLT;                      // RL7
		if (sck_rise)
			next_sr = {sr[SR_BITS-2:0], din_s2};            // RL1
		if (sck_fall)
			next_dout_q = sr[SR_BITS-1];                    // RL2 RL5
		if (cs_rise)                                        // RL4
		begin
			if (cmd.rd)
				next_sr = {sr[15:8], rd_reg(cmd.addr)};
			else if (cmd.addr < 7'(NUM_PORTS))
				next_port_code[cmd.addr[3:0]] = cmd.data;   // RL13 RL14
			else if (cmd.addr == ADDR_CFG)
			begin
				next_run     = cmd.data[CFG_RUN_BIT];       // RL17
				next_clk_sel = cmd.data[CFG_CLKIN_BIT];     // RL8 RL19
			end
			else if (cmd.addr == ADDR_FULL_LO)
				next_full_q[7:0] = cmd.data;                // RL15
			else if (cmd.addr == ADDR_FULL_HI)
				next_full_q[9:8] = cmd.data[1:0];           // RL15
			else if (cmd.addr == ADDR_GLOB)
				next_glob_q = cmd.data[2:0];                // RL16
		end
		// pwm timebase: pin clock or internal divider
		if (clk_sel)
		begin
			next_tick_cnt = 16'h0000;
			if (pck_rise)
				next_pwm_cnt = pwm_cnt + 8'h01;             // RL6
		end
		else if (tick_cnt >= 16'(TICK_CYC - 1))
		begin
			next_tick_cnt = 16'h0000;
			next_pwm_cnt  = pwm_cnt + 8'h01;
		end
		else
			next_tick_cnt = tick_cnt + 16'h0001;
		for (int i = 0; i < NUM_PORTS; i++)
			next_oe_n_q[i] = port_oe_n(port_code[i], run, pwm_cnt); // RL18
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sr         <= '0;
			dout_q     <= 1'b0;
			for (int i = 0; i < NUM_PORTS; i++)
				port_code[i] <= RST_PORT_CODE;              // RL10 RL11
			full_q     <= RST_FULL;
			glob_q     <= RST_GLOB;
			run        <= 1'b0;                             // RL12
			clk_sel    <= 1'b0;
			strap_done <= 1'b0;
			pwm_cnt    <= 8'h00;
			tick_cnt   <= 16'h0000;
			oe_n_q     <= '1;                               // RL10
		end
		else
		begin
			sr         <= next_sr;
			dout_q     <= next_dout_q;
			port_code  <= next_port_code;
			full_q     <= next_full_q;
			glob_q     <= next_glob_q;
			run        <= next_run;
			clk_sel    <= next_clk_sel;
			strap_done <= next_strap_done;
			pwm_cnt    <= next_pwm_cnt;
			tick_cnt   <= next_tick_cnt;
			oe_n_q     <= next_oe_n_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs; ports are open drain, so they only ever pull low

	assign dual_out       = dout_q;
	assign dual_oe_n      = clk_sel;                        // RL19
	assign io_ports_out   = '0;
	assign io_ports_oe_n  = oe_n_q;
	assign current_full   = full_q;
	assign global_current = glob_q;
	assign shutdown       = ~run;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	shift_in_a: assert property ( // RL1
		sck_rise |=> sr == {$past(sr[14:0]), $past(din_s2)})
		else $error("serial bit not shifted in");

	dout_fall_a: assert property ( // RL2
		sck_fall |=> dual_out == $past(sr[15]))
		else $error("serial output not updated on fall");

	dout_hold_a: assert property ( // RL5
		!sck_fall |=> $stable(dual_out))
		else $error("serial output moved without a fall");

	cs_idle_a: assert property ( // RL3
		(cs_s2 && cs_d) |=> $stable(sr))
		else $error("shift register moved while deselected");

	cfg_latch_a: assert property ( // RL4
		(cs_rise && !cmd.rd && cmd.addr == ADDR_CFG)
		|=> run == $past(cmd.data[0]) && clk_sel == $past(cmd.data[1]))
		else $error("config word not latched on select rise");

	stay_down_a: assert property ( // RL12
		(!run && !(cs_rise && !cmd.rd && cmd.addr == ADDR_CFG)) |=> !run)
		else $error("left shutdown without a write");

	off_hiz_a: assert property ( // RL10
		port_code[0] == CODE_OFF |=> io_ports_oe_n[0])
		else $error("port off but driven");

	low_drive_a: assert property ( // RL18
		port_code[0] == CODE_LOW ##1 port_code[0] == CODE_LOW
		|-> !io_ports_oe_n[0])
		else $error("logic low code not driving");

	sd_sink_a: assert property ( // RL17
		(!run && port_code[0] >= CODE_STATIC) |=> io_ports_oe_n[0])
		else $error("sink active in shutdown");

	pwm_step_a: assert property ( // RL6
		(clk_sel && pck_rise) |=> pwm_cnt == $past(pwm_cnt) + 8'h01)
		else $error("pin clock did not step pwm");

	int_tick_a: assert property ( // RL6
		(!clk_sel && tick_cnt >= 16'(TICK_CYC - 1))
		|=> pwm_cnt == $past(pwm_cnt) + 8'h01)
		else $error("internal tick did not step pwm");

	strap_default_a: assert property ( // RL7
		!strap_done |=> clk_sel == CLKIN_DFLT)
		else $error("pin mode not at variant default");

	port_latch_a: assert property ( // RL13
		(cs_rise && !cmd.rd && cmd.addr == ADDR_PORT0)
		|=> port_code[0] == $past(cmd.data))
		else $error("port code not latched");

	full_latch_a: assert property ( // RL15
		(cs_rise && !cmd.rd && cmd.addr == ADDR_FULL_LO)
		|=> current_full[7:0] == $past(cmd.data))
		else $error("full current bits not latched");

	glob_latch_a: assert property ( // RL16
		(cs_rise && !cmd.rd && cmd.addr == ADDR_GLOB)
		|=> global_current == $past(cmd.data[2:0]))
		else $error("global scale not latched");

	read_load_a: assert property ( // RL4
		(cs_rise && cmd.rd && cmd.addr == ADDR_FULL_LO)
		|=> sr == {$past(sr[15:8]), $past(full_q[7:0])})
		else $error("read data not loaded for shifting");

	static_run_a: assert property ( // RL18
		(run && port_code[1] == CODE_STATIC) |=> !io_ports_oe_n[1])
		else $error("static sink not active while running");

	pwm_sink_a: assert property ( // RL14
		(run && port_code[2] > CODE_STATIC && port_code[2] != CODE_OFF
		&& pwm_cnt < port_code[2]) |=> !io_ports_oe_n[2])
		else $error("pwm port not sinking in its on time");
endmodule : lxs_serial_port

/* verilog/lxs_pkg.sv */
// What this block does
// RL1: each serial clock rise shifts the input bit into a 16-bit register.
// RL2: the serial output changes on each serial clock fall.
// RL3: serial clock edges are ignored while chip select is high.
// RL4: chip select rise latches the last 16 bits; host sends command last.
// RL5: input bits reach the serial output 15.5 serial clocks later.
// RL6: in clock-input mode the pin's square wave times the PWM.
// RL7: dual-function pin power-up default depends on product variant.
// RL8: software may set the dual-function pin either way in both variants.
// RL9: host selects serial output when reading inputs or checking writes.
// RL10: all ten ports are high impedance after power-up.
// RL11: power-up high impedance is not an input setting until written.
// RL12: the device starts in shutdown.
// RL13: each port is a current sink, logic input or open-drain output.
// RL14: each current-sink port has its own 8-bit PWM setting.
// RL15: each current-sink port has its own half/full current bit.
// RL16: one global 3-bit current scale applies to all sink outputs.
// RL17: clearing run bit D0 enters shutdown; setting it leaves shutdown.
// RL18: codes 00 low, 01 high/input, 02 static, 03-FE PWM, FF off.
// RL19: dual-function pin mode is a configuration bit written serially.
package lxs_pkg;
	localparam int NUM_PORTS = 10;
	localparam int SR_BITS   = 16;

	// serial word: read flag, register address, data byte
	typedef struct packed {
		logic       rd;
		logic [6:0] addr;
		logic [7:0] data;
	} lxs_cmd_t;

	localparam logic [6:0] ADDR_PORT0   = 7'h00;
	localparam logic [6:0] ADDR_IN_LO   = 7'h0E;
	localparam logic [6:0] ADDR_IN_HI   = 7'h0F;
	localparam logic [6:0] ADDR_CFG     = 7'h10;
	localparam logic [6:0] ADDR_FULL_LO = 7'h11;
	localparam logic [6:0] ADDR_FULL_HI = 7'h12;
	localparam logic [6:0] ADDR_GLOB    = 7'h13;

	localparam int CFG_RUN_BIT   = 0;
	localparam int CFG_CLKIN_BIT = 1;

	localparam logic [7:0] CODE_LOW    = 8'h00;
	localparam logic [7:0] CODE_HIGH   = 8'h01;
	localparam logic [7:0] CODE_STATIC = 8'h02;
	localparam logic [7:0] CODE_OFF    = 8'hFF;

	localparam logic [7:0] RST_PORT_CODE = CODE_OFF;
	localparam logic [9:0] RST_FULL      = 10'h000;
	localparam logic [2:0] RST_GLOB      = 3'h7;

	// internal PWM step rate, at the top of its frequency range
	localparam longint CLK_HZ       = 200000000;
	localparam longint INT_PWM_HZ   = 45000;
	localparam int     INT_TICK_CYC = int'(CLK_HZ / INT_PWM_HZ);
endpackage : lxs_pkg

/* tb/lxs_host.sv */
`timescale 1ns/10ps
module lxs_host (
	output logic        sclk,   // serial clock
	output logic        cs_n,   // chip select
	output logic        din,    // serial data
	input  wire logic   dout,   // pin level
	output logic [15:0] rx,     // last 16 bits seen
	output logic        rx_stb  // toggles per frame
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		rx = 16'h0000;
		rx_stb = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// bits go msb first; the command rides in the last 16
	task automatic frame(input logic [23:0] w, input int n);
		#1.3 cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			din = w[i];
			#24 sclk = 1'b1;
			#12 rx = {rx[14:0], dout};
			#12 sclk = 1'b0;
		end
		// output holds until the next fall, so read it late
		#36 rx = {rx[14:0], dout};
		cs_n = 1'b1;
		din = ~din;
		#48 rx_stb = ~rx_stb;
	endtask : frame
	// clock edges with chip select high
	task automatic noise();
		for (int i = 0; i < 16; i++)
		begin
			din = i[0];
			#24 sclk = 1'b1;
			#24 sclk = 1'b0;
		end
	endtask : noise
endmodule : lxs_host

/* tb/tb_lxs_serial_port.sv */
`timescale 1ns/10ps
module tb_lxs_serial_port;
	import lxs_pkg::*;
	logic                 clk, arst_n, pclk, sclk, cs_n, din, rx_stb;
	logic                 dual_out, dual_oe_n, shutdown;
	logic [NUM_PORTS-1:0] ext, p_out, p_oe_n, full;
	logic [2:0]           glob;
	logic [15:0]          rx;
	logic [15:0]          exp_q[$];
	logic [7:0]           r;
	int                   bad_count, cmp_count, lo;
	wire                  pin = dual_oe_n ? pclk : dual_out;
	wire [NUM_PORTS-1:0]  p_lvl = ext & p_oe_n;

	lxs_serial_port #(.TICK_CYC(4), .CLKIN_DFLT(1'b0)) lxs_serial_port_i (
		.clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dual_in(pin), .dual_out(dual_out), .dual_oe_n(dual_oe_n),
		.io_ports_in(p_lvl), .io_ports_out(p_out), .io_ports_oe_n(p_oe_n),
		.current_full(full), .global_current(glob), .shutdown(shutdown));
	lxs_host lxs_host_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(pin),
		.rx(rx), .rx_stb(rx_stb));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask : check
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		lxs_host_i.frame({8'h00, 1'b0, a, d}, 16);
		repeat (10) @(negedge clk);
	endtask : wr
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(rx_stb)
		if (exp_q.size() > 0)
			check(rx, exp_q.pop_front());
	initial
	begin
		#400000;
		bad_count++;
		wrap_up();
	end
	initial
	begin
		arst_n = 1'b0;
		pclk = 1'b0;
		void'($urandom(32'hE5AA9021));
		ext = 10'($urandom);
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(negedge clk);
		check(16'(shutdown), 16'h0001);
		check(16'(p_oe_n), 16'h03FF);
		check(16'(full), 16'(RST_FULL));
		check(16'(glob), 16'(RST_GLOB));
		check(16'(dual_oe_n), 16'h0000);
		check(16'(p_out), 16'h0000);
		// eight leading bits must fall out
		lxs_host_i.frame({8'($urandom), 1'b0, ADDR_CFG, 8'h01}, 24);
		repeat (10) @(negedge clk);
		check(16'(shutdown), 16'h0000);
		// inputs and a port code read back while every port is released
		lxs_host_i.frame({8'h00, 1'b1, ADDR_IN_LO, 8'h00}, 16);
		@(negedge clk);
		exp_q.push_back({ADDR_IN_LO, ext[7:0], 1'b1});
		lxs_host_i.frame({8'h00, 1'b1, ADDR_PORT0 + 7'h03, 8'h00}, 16);
		@(negedge clk);
		exp_q.push_back({ADDR_PORT0 + 7'h03, RST_PORT_CODE, 1'b0});
		wr(ADDR_PORT0, CODE_LOW);
		wr(ADDR_PORT0 + 7'h01, CODE_STATIC);
		check(16'(p_oe_n[1:0]), 16'h0000);
		r = 8'($urandom);
		wr(ADDR_FULL_LO, r);
		check(16'(full[7:0]), 16'(r));
		wr(ADDR_FULL_HI, {6'h00, r[7:6]});
		check(16'(full), 16'({r[7:6], r}));
		wr(ADDR_GLOB, {5'h00, r[2:0]});
		check(16'(glob), 16'(r[2:0]));
		// read back with the pin as serial out; stray edges in between
		lxs_host_i.frame({8'h00, 1'b1, ADDR_FULL_LO, 8'h00}, 16);
		lxs_host_i.noise();
		exp_q.push_back({ADDR_FULL_LO, r, 1'b0});
		lxs_host_i.frame({8'h00, 1'b0, 7'h7F, r}, 16);
		wr(ADDR_CFG, 8'h00);
		check(16'(p_oe_n[1:0]), 16'h0002);
		wr(ADDR_PORT0 + 7'h02, 8'h80);
		check(16'(p_oe_n[2]), 16'h0001);
		// internal timebase: 256 steps of 4 cycles, half of them off
		wr(ADDR_CFG, 8'h01);
		lo = 0;
		repeat (1024) @(negedge clk) lo += p_oe_n[2];
		check(16'(lo >= 508 && lo <= 516), 16'h0001);
		wr(ADDR_CFG, 8'h03);
		check(16'(dual_oe_n), 16'h0001);
		lo = 0;
		repeat (1000) @(negedge clk) lo += p_oe_n[2];
		check(16'(lo == 0 || lo == 1000), 16'h0001);
		// pin clock far faster than the part allows, to keep the run short
		lo = 0;
		repeat (512)
		begin
			repeat (5) @(posedge clk);
			pclk <= ~pclk;
			@(negedge clk);
			lo += p_oe_n[2];
		end
		check(16'(lo >= 250 && lo <= 262), 16'h0001);
		wr(ADDR_CFG, 8'h01);
		check(16'(dual_oe_n), 16'h0000);
		wrap_up();
	end
endmodule : tb_lxs_serial_port
